//--- pkg/mppc_regs.vh
// constants for the multiplexed pixel port capture stage
// assumes inclusion by bare name from rtl files
`ifndef MPPC_REGS_VH
`define MPPC_REGS_VH
`define MPPC_SETS          8
`define MPPC_CHAN_W        8
`define MPPC_PIX_W         24
`define MPPC_PORT_W        64
`define MPPC_FIFO_DEPTH    8
`define MPPC_FIFO_AW       3
`define MPPC_WORD_W        28
`define MPPC_SET_LAST      3'h7
// pixel clock enable divider: pixel slot every PIX_DIV+1 ref_clk cycles
`define MPPC_PIX_DIV       3'h1
`define MPPC_BLANK_LVL     8'h00
`define MPPC_PED_LVL       8'h10
`endif

//--- rtl/mppc_fifo.v
// generic valid/ready fifo with width and depth parameters
// assumes one clock, asynchronous active-high reset
module mppc_fifo #(
    parameter W  = 28,
    parameter D  = 8,
    parameter AW = 3
) (
    input  wire          ref_clk,
    input  wire          rst,
    input  wire [W-1:0]  in_data,
    input  wire          in_valid,
    output wire          in_ready,
    output wire [W-1:0]  out_data,
    output wire          out_valid,
    input  wire          out_ready
);
    reg [W-1:0]  mem [0:D-1];
    reg [AW-1:0] wp_r;
    reg [AW-1:0] rp_r;
    reg [AW:0]   cnt_r;
    wire         wr;
    wire         rd;

    assign in_ready  = (cnt_r != D);
    assign out_valid = (cnt_r != 0);
    assign out_data  = mem[rp_r];
    assign wr        = in_valid & in_ready;
    assign rd        = out_valid & out_ready;

    always @(posedge ref_clk)
    begin
        if (wr)
            mem[wp_r] <= in_data;
    end

    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wp_r  <= {AW{1'b0}};
            rp_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (wr)
                wp_r <= wp_r + 1'b1;
            if (rd)
                rp_r <= rp_r + 1'b1;
            if (wr & ~rd)
                cnt_r <= cnt_r + 1'b1;
            else if (rd & ~wr)
                cnt_r <= cnt_r - 1'b1;
        end
    end
endmodule // mppc_fifo

//--- rtl/mppc_capture.v
// capture stage of the wide multiplexed pixel port
// assumes pins are asynchronous to ref_clk; strobe much slower than ref_clk
//
// Operation
// [R1] capture eight 24-bit pixel sets per strobe rise
// [R2] blank low forces blanking level output
// [R3] blank and syncs sampled with pixel data
// [R4] pedestal select bit chooses blanking pedestal
// [R5] field parity: zero even, one odd
// [R6] controller changes parity only in vertical blank
// [R7] strobe is reference; pixel rate eight times (slots here come from a fixed divider instead)
// [R8] serialize sets A through H, one per slot
`include "mppc_regs.vh"
module mppc_capture (
    input  wire         ref_clk,
    input  wire         rst,
    input  wire         pixel_load_strobe,
    input  wire [63:0]  red_pixel_inputs,
    input  wire [63:0]  green_pixel_inputs,
    input  wire [63:0]  blue_pixel_inputs,
    input  wire         blank_n,
    input  wire         hsync_in,
    input  wire         vsync_in,
    input  wire         odd_even_in,
    input  wire         pedestal_select_bit,
    output reg  [7:0]   red_out,
    output reg  [7:0]   green_out,
    output reg  [7:0]   blue_out,
    output reg          blank_out,
    output reg          hsync_out,
    output reg          vsync_out,
    output reg          odd_field,
    output reg          pix_valid,
    output reg          overflow
);
    // pixel words from the pins pass two flops; data is held stable around
    // the strobe, so the bus sampled on the strobe edge is the one consumed
    reg [191:0] px_s1_r;
    reg [191:0] px_s2_r;
    reg [3:0]   ctl_s1_r;
    reg [3:0]   ctl_s2_r;
    reg         ld_s1_r;
    reg         ld_s2_r;
    reg         ld_d_r;
    reg         ped_s1_r;
    reg         ped_s2_r;
    reg [191:0] set_r;
    reg [3:0]   ctl_r;
    reg         busy_r;
    reg [2:0]   idx_r;
    reg [2:0]   div_r;
    wire        ld_rise;
    wire        slot_en;
    wire        f_in_ready;
    wire [27:0] f_out_data;
    wire        f_out_valid;
    wire        f_out_ready;
    wire [27:0] f_in_data;
    wire [2:0]  idx_nxt;

    function [23:0] pick_set;
        input [191:0] s;
        input [2:0]   i;
        begin
            pick_set = s[i*24 +: 24];
        end
    endfunction

    function [7:0] lane;
        input [63:0] bus;
        input [2:0]  i;
        begin
            lane = bus[i*8 +: 8];
        end
    endfunction

    // blanking level, raised to the pedestal when selected
    function [7:0] blank_lvl;
        input ped;
        begin
            blank_lvl = ped ? `MPPC_PED_LVL : `MPPC_BLANK_LVL;
        end
    endfunction

    // set A sits in the low byte of each colour bus
    integer k;
    reg [191:0] px_pack;
    always @*
    begin
        px_pack = 192'h0;
        for (k = 0; k < 8; k = k + 1)
            px_pack[k*24 +: 24] = {lane(red_pixel_inputs, k[2:0]),
                                   lane(green_pixel_inputs, k[2:0]),
                                   lane(blue_pixel_inputs, k[2:0])};
    end

    // slots are paced by a fixed divider, not by the strobe period; a strobe
    // arriving before eight slots are out restarts the line and flags overflow
    assign ld_rise     = ld_s2_r & ~ld_d_r; // [R7]
    assign slot_en     = (div_r == `MPPC_PIX_DIV);
    assign idx_nxt     = idx_r + 3'h1;
    assign f_in_data   = {ctl_r, pick_set(set_r, idx_r)};
    assign f_out_ready = 1'b1;

    // two-flop synchronisers for every pin; the second stage is read, and on the strobe a third flop too
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            px_s1_r  <= 192'h0;
            px_s2_r  <= 192'h0;
            ctl_s1_r <= 4'h1;
            ctl_s2_r <= 4'h1;
            ld_s1_r  <= 1'b0;
            ld_s2_r  <= 1'b0;
            ld_d_r   <= 1'b0;
            ped_s1_r <= 1'b0;
            ped_s2_r <= 1'b0;
        end
        else
        begin
            px_s1_r  <= px_pack;
            px_s2_r  <= px_s1_r;
            ctl_s1_r <= {blank_n, hsync_in, vsync_in, odd_even_in};
            ctl_s2_r <= ctl_s1_r;
            ld_s1_r  <= pixel_load_strobe;
            ld_s2_r  <= ld_s1_r;
            ld_d_r   <= ld_s2_r;
            ped_s1_r <= pedestal_select_bit;
            ped_s2_r <= ped_s1_r;
        end
    end

    // capture and serialize; a new strobe restarts at set A
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            set_r    <= 192'h0;
            ctl_r    <= 4'h8;
            busy_r   <= 1'b0;
            idx_r    <= 3'h0;
            div_r    <= 3'h0;
            overflow <= 1'b0;
        end
        else
        begin
            div_r <= slot_en ? 3'h0 : div_r + 3'h1;
            if (ld_rise)
            begin
                set_r    <= px_s2_r;   // [R1]
                ctl_r    <= ctl_s2_r;  // [R3]
                idx_r    <= 3'h0;
                busy_r   <= 1'b1;
                overflow <= busy_r;    // previous line not fully sent
            end
            else if (busy_r & slot_en & f_in_ready)
            begin
                idx_r <= idx_nxt; // [R8]
                if (idx_r == `MPPC_SET_LAST)
                    busy_r <= 1'b0;
            end
        end
    end

    // the drain never stalls, so in_ready only matters if the output stage
    // ever gains back-pressure
    mppc_fifo #(
        .W  (`MPPC_WORD_W),
        .D  (`MPPC_FIFO_DEPTH),
        .AW (`MPPC_FIFO_AW)
    ) u_mppc_fifo (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .in_data   (f_in_data),
        .in_valid  (busy_r & slot_en & ~ld_rise),
        .in_ready  (f_in_ready),
        .out_data  (f_out_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready)
    );

    // output stage; blank wins over colour data
    // pedestal bit is taken live from its second sync flop, so a change shows only in words written two cycles later or after
    always @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            red_out   <= `MPPC_BLANK_LVL;
            green_out <= `MPPC_BLANK_LVL;
            blue_out  <= `MPPC_BLANK_LVL;
            blank_out <= 1'b1;
            hsync_out <= 1'b0;
            vsync_out <= 1'b0;
            odd_field <= 1'b0;
            pix_valid <= 1'b0;
        end
        else
        begin
            pix_valid <= f_out_valid;
            if (f_out_valid)
            begin
                hsync_out <= f_out_data[26];
                vsync_out <= f_out_data[25];
                odd_field <= f_out_data[24]; // [R5] [R6]
                blank_out <= ~f_out_data[27];
                if (!f_out_data[27])
                begin
                    // [R2] [R4]
                    red_out   <= blank_lvl(ped_s2_r);
                    green_out <= blank_lvl(ped_s2_r);
                    blue_out  <= blank_lvl(ped_s2_r);
                end
                else
                begin
                    red_out   <= f_out_data[23:16];
                    green_out <= f_out_data[15:8];
                    blue_out  <= f_out_data[7:0];
                end
            end
        end
    end
endmodule // mppc_capture

//--- tb/mppc_props.sv
// checker: output timing of the pixel port capture stage
// assumes bind onto mppc_capture, one clock domain
module mppc_props (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       pixel_load_strobe,
    input wire logic       pedestal_select_bit,
    input wire logic [7:0] red_out,
    input wire logic [7:0] green_out,
    input wire logic [7:0] blue_out,
    input wire logic       blank_out,
    input wire logic       hsync_out,
    input wire logic       odd_field,
    input wire logic       pix_valid,
    input wire logic       overflow
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [7:0] age_r;
    // cycles since the last strobe rise, saturating
    always @(posedge ref_clk or posedge rst)
        if (rst)
            age_r <= 8'hff;
        else if ($rose(pixel_load_strobe))
            age_r <= 8'h00;
        else if (age_r != 8'hff)
            age_r <= age_r + 8'h01;
    // levels are only written with a new word; the pedestal bit reaches the
    // output flop through two sync stages, so the word shows the value of 3 cycles ago
    property p_blank;
        pix_valid && blank_out && !$past(pedestal_select_bit, 3)
            |-> {red_out, green_out, blue_out} == 24'h000000;
    endproperty
    a_blank: assert property (p_blank) else $error("blank level wrong");
    property p_ped;
        pix_valid && blank_out && $past(pedestal_select_bit, 3)
            |-> {red_out, green_out, blue_out} == 24'h101010;
    endproperty
    a_ped: assert property (p_ped) else $error("pedestal level wrong");
    property p_gap;
        pix_valid |=> !pix_valid;
    endproperty
    a_gap: assert property (p_gap) else $error("slots too close");
    property p_answer;
        $rose(pixel_load_strobe) |-> ##[4:14] pix_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no pixel after strobe");
    property p_late;
        pix_valid |-> age_r < 8'd28;
    endproperty
    a_late: assert property (p_late) else $error("pixel without strobe");
    property p_ctl_hold;
        !pix_valid |-> $stable({blank_out, hsync_out, odd_field});
    endproperty
    a_ctl_hold: assert property (p_ctl_hold) else $error("control moved");
    property p_hold;
        !pix_valid && !blank_out |-> $stable({red_out, green_out, blue_out});
    endproperty
    a_hold: assert property (p_hold) else $error("colour moved");
    property p_ovf;
        !$stable(overflow) |-> age_r < 8'd8;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow off strobe");
    cover property (pix_valid && blank_out);
    cover property ($rose(overflow));
    cover property (pix_valid && odd_field);
endmodule // mppc_props
bind mppc_capture mppc_props u_mppc_props (.ref_clk, .rst, .pixel_load_strobe,
    .pedestal_select_bit, .red_out, .green_out, .blue_out, .blank_out, .hsync_out,
    .odd_field, .pix_valid, .overflow);

//--- tb/mppc_ctrl_model.sv
// frame-buffer controller model: one strobe of 24 ns per send
// assumes calls start on a falling edge of ref_clk
module mppc_ctrl_model (
    input  wire logic        ref_clk,
    output logic             stb,
    output logic [63:0]      r,
    output logic [63:0]      g,
    output logic [63:0]      b,
    output logic             bl_n,
    output logic             hs,
    output logic             vs,
    output logic             oe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {stb, r, g, b, bl_n, hs, vs, oe} = '0;
    // c is {blank_n, hsync, vsync, odd_even}; strobe idles low between frames
    task send(input logic [63:0] nr, ng, nb, input logic [3:0] c);
        @(negedge ref_clk);
        {r, g, b, bl_n, hs, vs} = {nr, ng, nb, c[3:1]};
        if (c[1])
            oe = c[0];
        repeat (5) @(negedge ref_clk);
        stb = 1;
        repeat (3) @(negedge ref_clk);
        // hold time over: show the inverse so stale data cannot pass
        {r, g, b} = ~{r, g, b};
        repeat (3) @(negedge ref_clk);
        stb = 0;
    endtask
endmodule // mppc_ctrl_model

//--- tb/tb_multiplexed_pixel_port_capture.sv
// self-checking bench for the pixel port capture stage
// assumes the controller model drives all port pins but the pedestal select
`include "mppc_regs.vh"
module tb_multiplexed_pixel_port_capture;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst = 1, ped = 0, fld = 0;
    int miscompares = 0, tests_run = 0, cyc = 0;
    logic stb, bl_n, hs, vs, oe, bk, hso, vso, od, pv, ov;
    logic [63:0] r, g, b;
    logic [7:0] ro, go, bo;
    mppc_ctrl_model u_mppc_ctrl_model (.ref_clk(ref_clk), .stb(stb), .r(r), .g(g), .b(b),
        .bl_n(bl_n), .hs(hs), .vs(vs), .oe(oe));
    mppc_capture u_mppc_capture (.ref_clk(ref_clk), .rst(rst), .pixel_load_strobe(stb),
        .red_pixel_inputs(r), .green_pixel_inputs(g), .blue_pixel_inputs(b),
        .blank_n(bl_n), .hsync_in(hs), .vsync_in(vs), .odd_even_in(oe),
        .pedestal_select_bit(ped), .red_out(ro), .green_out(go), .blue_out(bo),
        .blank_out(bk), .hsync_out(hso), .vsync_out(vso), .odd_field(od),
        .pix_valid(pv), .overflow(ov));
    always #2 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            miscompares++;
            close_out();
        end
    end
    task chk(input logic [63:0] v, e);
        tests_run++;
        if (v !== e)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, v, e);
        end
    endtask
    task send_chk(input logic [63:0] nr, ng, nb, input logic [3:0] c);
        logic [7:0] lv;
        int n;
        lv = ped ? `MPPC_PED_LVL : `MPPC_BLANK_LVL;
        if (c[1])
            fld = c[0];
        fork
            u_mppc_ctrl_model.send(nr, ng, nb, c);
            for (int k = 0; k < 8; k++)
            begin
                n = 0;
                while (pv !== 1'b1 && n < 40)
                begin
                    @(negedge ref_clk);
                    n++;
                end
                chk({ro, go, bo}, c[3] ? {nr[8*k+:8], ng[8*k+:8], nb[8*k+:8]} : {3{lv}});
                chk({bk, hso, vso, od}, {~c[3], c[2], c[1], fld});
                @(negedge ref_clk);
            end
        join
        chk(ov, 0);
    endtask
    task t_order;
        send_chk(64'h0706050403020100, 64'h1716151413121110, 64'hf7e6d5c4b3a29180, 4'hc);
        $display("t_order done");
    endtask
    task t_blank;
        send_chk('1, '1, '1, 4'h0);
        ped = 1;
        send_chk('1, 64'h5a5a, '1, 4'h4);
        ped = 0;
        $display("t_blank done");
    endtask
    task t_field;
        send_chk(64'h8877665544332211, '0, '1, 4'hb);
        send_chk('0, 64'h0123456789abcdef, '0, 4'ha);
        $display("t_field done");
    endtask
    task t_ovf;
        u_mppc_ctrl_model.send('1, '0, '1, 4'h8);
        u_mppc_ctrl_model.send('0, '1, '0, 4'h8);
        repeat (24) @(negedge ref_clk);
        chk(ov, 1);
        $display("t_ovf done");
    endtask
    task close_out;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge ref_clk);
        chk({ro, go, bo, bk, pv, ov}, 27'h4);
        rst = 0;
        t_order;
        t_blank;
        t_field;
        t_ovf;
        t_order;
        close_out();
    end
endmodule // tb_multiplexed_pixel_port_capture
